// [hw/acs_ctrl.sv]
// converter control: config, clock select, sequencing, results, irq
// assumes: apb master on clock, analog front end drives conv_data pins
// Contract
// - format 1: right justify, high six bits zero
// - format 0: left justify, low six bits zero
// - divider msb and select pick clock ratio
// - low select 11 uses internal rc clock
// - config bits 5 and 4 read zero
// - port code sets each pin analog/digital
// - port code also selects voltage references
// - reset forces all shared pins analog
// - completion loads result, clears go, sets done
// - go with power on starts conversion
// - clearing go aborts, result unchanged
// - conversion lasts twelve bit periods
// - three-bit select picks one of eight
`timescale 1ns/1ps
module acs_ctrl
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] conv_data,
  input wire logic rc_osc,
  output logic irq,
  output logic [7:0] analog_pin_mask,
  output logic vref_pos_ext,
  output logic vref_neg_ext,
  output logic [2:0] channel_select,
  output logic converter_power_on,
  output logic sample_hold
);

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [10:0] pin_s;
  logic rc_prev_q;

  acs_sync #(.W(11)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .d({rc_osc, conv_data}),
    .q(pin_s)
  );

  wire [9:0] data_s = pin_s[9:0];
  wire rc_rise = pin_s[10] & ~rc_prev_q;

  // ************************************************
  // apb decode
  // ************************************************
  logic [7:0] mc_q, mc_d;
  logic [7:0] cf_q;
  logic [7:0] res_hi_q, res_lo_q;
  logic [0:0] st_q, en_q;
  acs_state_t state_q, state_d;
  logic [5:0] div_cnt_q;
  logic [3:0] bitp_cnt_q;
  logic [9:0] sample_q;

  wire sel_mc = paddr == ACS_ADDR_MAIN;
  wire sel_cf = paddr == ACS_ADDR_CFG;
  wire sel_rh = paddr == ACS_ADDR_RES_HI;
  wire sel_rl = paddr == ACS_ADDR_RES_LO;
  wire sel_st = paddr == ACS_ADDR_IRQ_ST;
  wire sel_cl = paddr == ACS_ADDR_IRQ_CLR;
  wire sel_en = paddr == ACS_ADDR_IRQ_EN;
  wire hit = sel_mc | sel_cf | sel_rh | sel_rl | sel_st | sel_cl | sel_en;

  // zero wait states; ce low stalls the access phase
  assign pready = ce;
  assign pslverr = psel & penable & ~hit;

  wire wr = psel & penable & pwrite & ce & pstrb[0];
  wire wr_mc = wr & sel_mc;
  wire wr_cf = wr & sel_cf;
  wire wr_rh = wr & sel_rh;
  wire wr_rl = wr & sel_rl;
  wire wr_en = wr & sel_en;
  wire clr_done = wr & sel_cl & pwdata[ACS_IRQ_DONE];

  wire [7:0] rd_byte = sel_mc ? mc_q :
                       sel_cf ? (cf_q & ACS_CF_WMASK) :
                       sel_rh ? res_hi_q :
                       sel_rl ? res_lo_q :
                       sel_st ? {7'h00, st_q} :
                       sel_en ? {7'h00, en_q} : 8'h00;
  assign prdata = {24'h00_0000, rd_byte};

  // ************************************************
  // conversion clock
  // ************************************************
  wire [1:0] clk_low = mc_q[ACS_MC_CLK_LSB +: 2];
  wire [2:0] clk_code = {cf_q[ACS_CF_DIVMSB], clk_low};
  wire rc_mode = clk_low == ACS_CLK_RC;
  wire [6:0] ratio = ACS_DIV_RATIO[clk_code];
  wire div_wrap = {1'b0, div_cnt_q} == ratio - 7'h01;
  // rc edges are slow against clock, so sync latency is harmless
  wire bitp_tick = rc_mode ? rc_rise : div_wrap;

  // ************************************************
  // sequencing
  // ************************************************
  wire idle = state_q == ACS_ST_IDLE;
  wire conv = state_q == ACS_ST_CONV;
  wire go_wr = pwdata[ACS_MC_GO] & pwdata[ACS_MC_PWR];
  wire start = wr_mc & go_wr & idle;
  wire finish = ce & conv & bitp_tick & (bitp_cnt_q == ACS_CONV_PERIODS - 4'h1);
  wire abort = conv & wr_mc & ~go_wr & ~finish;

  always_comb begin
    state_d = state_q;
    if (start) begin
      state_d = ACS_ST_CONV;
    end else if (finish | abort) begin
      state_d = ACS_ST_IDLE;
    end
  end

  // go mirrors the state; a go write with power off is dropped
  always_comb begin
    mc_d = mc_q;
    if (wr_mc) begin
      mc_d = pwdata[7:0] & ACS_MC_WMASK;
    end
    mc_d[ACS_MC_GO] = state_d == ACS_ST_CONV;
  end

  wire just = cf_q[ACS_CF_JUST];
  wire [7:0] res_hi_new = just ? {6'h00, sample_q[9:8]} : sample_q[9:2];
  wire [7:0] res_lo_new = just ? sample_q[7:0] : {sample_q[1:0], 6'h00};

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ACS_ST_IDLE;
      mc_q <= ACS_MC_RST;
      cf_q <= ACS_CF_RST;
    end else if (ce) begin
      state_q <= state_d;
      mc_q <= mc_d;
      if (wr_cf) begin
        cf_q <= pwdata[7:0] & ACS_CF_WMASK;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 6'h00;
      bitp_cnt_q <= 4'h0;
      sample_q <= 10'h000;
      rc_prev_q <= 1'b0;
    end else if (ce) begin
      rc_prev_q <= pin_s[10];
      div_cnt_q <= (conv & ~div_wrap) ? div_cnt_q + 6'h01 : 6'h00;
      if (start) begin
        bitp_cnt_q <= 4'h0;
        sample_q <= data_s;
      end else if (conv & bitp_tick) begin
        bitp_cnt_q <= bitp_cnt_q + 4'h1;
      end
    end
  end

  // result pair: loaded on completion, else usable as plain storage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      res_hi_q <= ACS_RES_RST;
      res_lo_q <= ACS_RES_RST;
    end else if (ce) begin
      if (finish) begin
        res_hi_q <= res_hi_new;
        res_lo_q <= res_lo_new;
      end else begin
        if (wr_rh) begin
          res_hi_q <= pwdata[7:0];
        end
        if (wr_rl) begin
          res_lo_q <= pwdata[7:0];
        end
      end
    end
  end

  // done flag: set beats a same-cycle clear; reads never clear it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= 1'b0;
      en_q <= 1'b0;
    end else if (ce) begin
      st_q[ACS_IRQ_DONE] <= (st_q[ACS_IRQ_DONE] & ~clr_done) | finish;
      if (wr_en) begin
        en_q <= pwdata[0:0];
      end
    end
  end

  assign irq = |(st_q & en_q);

  // ************************************************
  // pin configuration outputs
  // ************************************************
  logic [7:0] mask_q;
  logic vpos_q, vneg_q;
  wire [3:0] port_code = cf_q[ACS_CF_PORT_LSB +: 4];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= ACS_MASK_RST;
      vpos_q <= 1'b0;
      vneg_q <= 1'b0;
    end else if (ce) begin
      mask_q <= ACS_PORT_ANALOG[port_code];
      vpos_q <= ACS_VPOS_CODES[port_code];
      vneg_q <= ACS_VNEG_CODES[port_code];
    end
  end

  assign analog_pin_mask = mask_q;
  assign vref_pos_ext = vpos_q;
  assign vref_neg_ext = vneg_q;
  assign channel_select = mc_q[ACS_MC_CHAN_LSB +: 3];
  assign converter_power_on = mc_q[ACS_MC_PWR];
  assign sample_hold = conv;

  // ************************************************
  // checks
  // ************************************************
  logic [9:0] cyc_q;
  logic [2:0] code_at_start_q;
  logic [9:0] exp_cyc;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= 10'h000;
      code_at_start_q <= 3'h0;
    end else if (ce) begin
      if (start) begin
        cyc_q <= 10'h000;
        code_at_start_q <= clk_code;
      end else if (conv) begin
        cyc_q <= cyc_q + 10'h001;
      end
    end
  end

  always_comb begin
    case (clk_code)
      3'h0: exp_cyc = 10'h018;
      3'h1: exp_cyc = 10'h060;
      3'h2: exp_cyc = 10'h180;
      3'h4: exp_cyc = 10'h030;
      3'h5: exp_cyc = 10'h0c0;
      3'h6: exp_cyc = 10'h300;
      default: exp_cyc = 10'h000;
    endcase
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_right;
    finish && just |=> res_hi_q[7:2] == 6'h00 && res_lo_q == $past(sample_q[7:0]);
  endproperty
  a_right: assert property (p_right) else $error("right justify wrong");

  property p_left;
    finish && !just |=> res_lo_q[5:0] == 6'h00 && res_hi_q == $past(sample_q[9:2]);
  endproperty
  a_left: assert property (p_left) else $error("left justify wrong");

  property p_conv_len;
    finish && !rc_mode && clk_code == code_at_start_q |-> cyc_q + 10'h001 == exp_cyc;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_rc;
    ce && conv && rc_mode && !rc_rise |=> $stable(bitp_cnt_q);
  endproperty
  a_rc: assert property (p_rc) else $error("tick without rc edge");

  property p_rsv;
    psel && sel_cf |-> prdata[5:4] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

  property p_port_code;
    ce && port_code[3:1] == 3'h3 |=> analog_pin_mask == 8'h00;
  endproperty
  a_port_code: assert property (p_port_code) else $error("digital code left analog pins");

  property p_vref;
    ce && port_code == 4'h8 |=> vref_pos_ext && vref_neg_ext && analog_pin_mask == 8'hff;
  endproperty
  a_vref: assert property (p_vref) else $error("reference select wrong");

  property p_done;
    finish |=> !mc_q[ACS_MC_GO] && st_q[ACS_IRQ_DONE] && idle;
  endproperty
  a_done: assert property (p_done) else $error("completion effects missing");

  property p_start;
    start |=> mc_q[ACS_MC_GO] && sample_hold ##1 (!ce || sample_hold || !mc_q[ACS_MC_GO]);
  endproperty
  a_start: assert property (p_start) else $error("go did not start");

  property p_abort;
    abort |=> idle && !mc_q[ACS_MC_GO] && $stable(res_hi_q) && $stable(res_lo_q);
  endproperty
  a_abort: assert property (p_abort) else $error("abort changed result");

  property p_sticky;
    st_q[ACS_IRQ_DONE] && !clr_done |=> st_q[ACS_IRQ_DONE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag lost");

  c_finish: cover property (finish);
  c_abort: cover property (abort);
  c_rc_finish: cover property (finish && rc_mode);
  c_irq: cover property (irq && clr_done);

endmodule // acs_ctrl

// [hw/acs_pkg.sv]
// constants, tables and types for the converter control block
// assumes: apb with 32-bit data, one register per aligned word
package acs_pkg;

  // ************************************************
  // register map: index, byte address is four times it
  // ************************************************
  localparam logic [9:0] ACS_IDX_RES_HI = 10'h01e;
  localparam logic [9:0] ACS_IDX_MAIN = 10'h01f;
  localparam logic [9:0] ACS_IDX_RES_LO = 10'h09e;
  localparam logic [9:0] ACS_IDX_CFG = 10'h09f;
  localparam logic [9:0] ACS_IDX_IRQ_ST = 10'h040;
  localparam logic [9:0] ACS_IDX_IRQ_CLR = 10'h041;
  localparam logic [9:0] ACS_IDX_IRQ_EN = 10'h042;

  localparam logic [11:0] ACS_ADDR_RES_HI = {ACS_IDX_RES_HI, 2'b00};
  localparam logic [11:0] ACS_ADDR_MAIN = {ACS_IDX_MAIN, 2'b00};
  localparam logic [11:0] ACS_ADDR_RES_LO = {ACS_IDX_RES_LO, 2'b00};
  localparam logic [11:0] ACS_ADDR_CFG = {ACS_IDX_CFG, 2'b00};
  localparam logic [11:0] ACS_ADDR_IRQ_ST = {ACS_IDX_IRQ_ST, 2'b00};
  localparam logic [11:0] ACS_ADDR_IRQ_CLR = {ACS_IDX_IRQ_CLR, 2'b00};
  localparam logic [11:0] ACS_ADDR_IRQ_EN = {ACS_IDX_IRQ_EN, 2'b00};

  // ************************************************
  // fields and reset values
  // ************************************************
  localparam int ACS_MC_CLK_LSB = 6;
  localparam int ACS_MC_CHAN_LSB = 3;
  localparam int ACS_MC_GO = 2;
  localparam int ACS_MC_PWR = 0;
  localparam int ACS_CF_JUST = 7;
  localparam int ACS_CF_DIVMSB = 6;
  localparam int ACS_CF_PORT_LSB = 0;
  localparam int ACS_IRQ_DONE = 0;
  localparam logic [7:0] ACS_MC_WMASK = 8'hfd;
  localparam logic [7:0] ACS_CF_WMASK = 8'hcf;
  localparam logic [7:0] ACS_MC_RST = 8'h00;
  localparam logic [7:0] ACS_CF_RST = 8'h00;
  localparam logic [7:0] ACS_RES_RST = 8'h00;
  localparam logic [7:0] ACS_MASK_RST = 8'hff;
  localparam logic [1:0] ACS_CLK_RC = 2'h3;

  // ************************************************
  // timing and lookup tables
  // ************************************************
  localparam logic [3:0] ACS_CONV_PERIODS = 4'hc;
  // indexed by {divider msb, low select}; rc slots unused
  localparam logic [6:0] ACS_DIV_RATIO [8] = '{7'h02, 7'h08, 7'h20, 7'h02,
                                              7'h04, 7'h10, 7'h40, 7'h02};
  // analog pin mask per port code, bit n is channel n
  localparam logic [7:0] ACS_PORT_ANALOG [16] = '{8'hff, 8'hff, 8'h1f, 8'h1f,
                                                 8'h0b, 8'h0b, 8'h00, 8'h00,
                                                 8'hff, 8'h3f, 8'h3f, 8'h3f,
                                                 8'h1f, 8'h0f, 8'h01, 8'h0d};
  localparam logic [15:0] ACS_VPOS_CODES = 16'hbd2a;
  localparam logic [15:0] ACS_VNEG_CODES = 16'hb900;

  typedef enum logic [1:0] {
    ACS_ST_IDLE = 2'b01,
    ACS_ST_CONV = 2'b10
  } acs_state_t;

endpackage

// [hw/acs_sync.sv]
// two-flop synchroniser for pin-level inputs
// assumes: inputs are asynchronous to clock; ce freezes it
`timescale 1ns/1ps
module acs_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // meta_q is read only by q
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // acs_sync

// [test/acs_front_model.sv]
// analog front end model: result pins and the internal rc clock
// assumes: sample_hold from the control block marks a conversion
`timescale 1ns/1ps
module acs_front_model #(
  // odd half period keeps rc rises off the rising clock edges
  parameter int RC_HALF_NS = 43
) (
  input wire logic sample_hold,
  input wire logic [9:0] level,
  output logic [9:0] conv_data,
  output logic rc_osc
);
  // ************************************************
  // pins and clock
  // ************************************************
  // bench settles the level an acquisition time before go
  assign conv_data = level;
  // rc clock stands still outside a conversion, so no stray bit periods
  initial begin
    rc_osc = 1'b0;
    forever begin
      wait (sample_hold === 1'b1);
      #(RC_HALF_NS);
      rc_osc = 1'b1;
      #(RC_HALF_NS);
      rc_osc = 1'b0;
    end
  end
endmodule // acs_front_model

// [test/tb_top.sv]
// self-checking bench for the converter control block
// assumes: acs_pkg map, apb answers when ce is high, front end model
`timescale 1ns/1ps
module tb_top
  import acs_pkg::*;
;
  logic clock, rst_n, ce, psel, penable, pwrite, pready, pslverr, err;
  logic irq, vpos, vneg, pwr, sh, rc_osc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [9:0] conv_data, level;
  logic [7:0] amask;
  logic [2:0] chsel, ch;
  logic [15:0] res_model;
  int miscompares, compares, n, i;
  // expected pin map and reference codes, worked out from the port table
  logic [7:0] amap [16] = '{8'hff, 8'hff, 8'h1f, 8'h1f, 8'h0b, 8'h0b, 8'h00, 8'h00,
                            8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h1f, 8'h0f, 8'h01, 8'h0d};
  logic [15:0] vp = 16'hbd2a;
  logic [15:0] vn = 16'hb900;
  int ratio [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  acs_ctrl i_acs_ctrl (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_data(conv_data), .rc_osc(rc_osc), .irq(irq),
    .analog_pin_mask(amask), .vref_pos_ext(vpos), .vref_neg_ext(vneg),
    .channel_select(chsel), .converter_power_on(pwr), .sample_hold(sh));
  acs_front_model i_acs_front_model (.sample_hold(sh), .level(level), .conv_data(conv_data),
    .rc_osc(rc_osc));

  always #5 clock = ~clock;

  // ************************************************
  // tasks
  // ************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask

  // one conversion; expn 0 means the rc clock, whose period only the model knows
  task conv(input logic [2:0] clk, input logic right, input int expn);
    level <= 10'($urandom);
    ch = 3'($urandom);
    apb(1'b1, ACS_ADDR_CFG, {right, clk[2], 6'h00});
    apb(1'b1, ACS_ADDR_MAIN, {clk[1:0], ch, 3'b001});
    apb(1'b1, ACS_ADDR_IRQ_CLR, 8'h01);
    #1 chk(irq, 1'b0);
    repeat (200) @(posedge clock);
    apb(1'b1, ACS_ADDR_MAIN, {clk[1:0], ch, 3'b101});
    #1 chk(sh, 1'b1);
    chk({chsel, pwr}, {ch, 1'b1});
    n = 0;
    while (sh === 1'b1 && n < 2000) begin
      @(posedge clock);
      #1 n++;
    end
    if (expn > 0) chk(n, expn);
    else chk(n >= 90 && n <= 110, 1);
    res_model = right ? {6'h00, level} : {level, 6'h00};
    chk(irq, 1'b1);
    rd_chk(ACS_ADDR_RES_HI, res_model[15:8]);
    rd_chk(ACS_ADDR_RES_LO, res_model[7:0]);
    rd_chk(ACS_ADDR_MAIN, {clk[1:0], ch, 3'b001});
    rd_chk(ACS_ADDR_IRQ_ST, 8'h01);
  endtask

  task report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ************************************************
  // sequence
  // ************************************************
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    level = 10'h000;
    miscompares = 0;
    compares = 0;
    void'($urandom(32'hc294));
    repeat (16) @(posedge clock);
    chk(amask, 8'hff);
    rst_n <= 1'b1;
    rd_chk(ACS_ADDR_CFG, 8'h00);
    rd_chk(ACS_ADDR_MAIN, 8'h00);
    apb(1'b1, ACS_ADDR_CFG, 8'hff);
    rd_chk(ACS_ADDR_CFG, 8'hcf);
    for (i = 0; i < 16; i++) begin
      apb(1'b1, ACS_ADDR_CFG, i[7:0]);
      repeat (2) @(posedge clock);
      #1 chk(amask, amap[i]);
      chk({vpos, vneg}, {vp[i], vn[i]});
    end
    // second reset with a mostly digital code loaded
    @(posedge clock);
    rst_n <= 1'b0;
    #1 chk(amask, 8'hff);
    rd_chk(ACS_ADDR_CFG, 8'h00);
    rst_n <= 1'b1;
    apb(1'b1, ACS_ADDR_IRQ_EN, 8'h01);
    for (i = 0; i < 8; i++) conv(i[2:0], i[0], 12 * ratio[i]);
    // enable masks the level output, status stays sticky
    apb(1'b1, ACS_ADDR_IRQ_EN, 8'h00);
    #1 chk(irq, 1'b0);
    apb(1'b1, ACS_ADDR_IRQ_EN, 8'h01);
    #1 chk(irq, 1'b1);
    apb(1'b1, ACS_ADDR_IRQ_CLR, 8'h01);
    rd_chk(ACS_ADDR_IRQ_ST, 8'h00);
    // abort the slowest conversion early, about 100 of its 768 cycles in
    level <= ~level;
    apb(1'b1, ACS_ADDR_MAIN, 8'h81);
    repeat (200) @(posedge clock);
    apb(1'b1, ACS_ADDR_MAIN, 8'h85);
    repeat (100) @(posedge clock);
    #1 chk(sh, 1'b1);
    apb(1'b1, ACS_ADDR_MAIN, 8'h81);
    #1 chk(sh, 1'b0);
    repeat (800) @(posedge clock);
    rd_chk(ACS_ADDR_RES_HI, res_model[15:8]);
    rd_chk(ACS_ADDR_RES_LO, res_model[7:0]);
    rd_chk(ACS_ADDR_IRQ_ST, 8'h00);
    apb(1'b1, ACS_ADDR_MAIN, 8'h04);
    rd_chk(ACS_ADDR_MAIN, 8'h00);
    apb(1'b1, ACS_ADDR_RES_HI, 8'h5a);
    rd_chk(ACS_ADDR_RES_HI, 8'h5a);
    apb(1'b0, 12'h004, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    report_and_stop;
  end

  initial begin
    #500000;
    miscompares++;
    report_and_stop;
  end
endmodule // tb_top
